// *** rtl/pds_host.sv ***
// Controller end: hardware reset sequencing, shadow bank management accesses and transmit nibble driving.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module pds_host #(
  parameter int RESET_WAIT_CYC = pds_pkg::RESET_WAIT_CYC_DEF // Quiet time after reset release.
) (
  input wire logic clock, // System clock, 50 MHz.
  input wire logic rst, // Synchronous reset, active high.
  pds_link_if.host link, // Management and transmit pins toward the transceiver.
  input wire logic req_wr, // Write request, one cycle.
  input wire logic req_rd, // Read request, one cycle.
  input wire logic [pds_pkg::PORT_W-1:0] req_port, // Target port.
  input wire logic [4:0] req_addr, // Register address.
  input wire logic [15:0] req_wdata, // Write data.
  output logic req_ready, // Request may be given this cycle.
  output logic resp_valid, // Read data valid, one cycle.
  output logic [15:0] resp_data, // Read data, reserved bits masked.
  output logic live, // Device may be used.
  input wire logic tx_ref_sel_in, // Time transmit pins to the reference clock.
  input wire logic [pds_pkg::PORT_W-1:0] tx_port, // Port that transmits.
  input wire logic tx_valid, // A nibble waits to go out.
  input wire logic [3:0] tx_nibble, // Nibble to send.
  output logic tx_take // Nibble taken, one cycle.
);
  import pds_pkg::*;

  typedef struct packed {
    pds_host_state_t state;
    logic [15:0] cnt;
    logic phy_rst;
    logic ref_clk;
    logic ref_sel;
    logic [PORT_W-1:0] mg_port;
    logic [4:0] mg_addr;
    logic [15:0] mg_wdata;
    logic mg_wr;
    logic mg_rd;
    logic rq_wr;
    logic [4:0] rq_addr;
    logic [15:0] rq_wdata;
    logic [NPORT-1:0] shadow_on;
    logic ready;
    logic resp_valid;
    logic [15:0] resp_data;
    logic live;
    logic [NPORT-1:0] tx_en;
    logic [NPORT-1:0][3:0] txd;
    logic [NPORT-1:0] txc_prev;
    logic tx_take;
  } pds_host_s_t;

  localparam pds_host_s_t HOST_RST = '{state: HS_RESET, phy_rst: 1'b1, default: '0};

  pds_host_s_t s_q;
  pds_host_s_t s_d;
  logic ev;

  // Reserved positions go out at their defaults; read-only registers get their reset pattern.
  function automatic logic [15:0] pds_merge(input logic [4:0] addr, input logic [15:0] wd);
    if (addr == REG_TEST) begin
      return (wd & TEST_SHADOW_MASK) | TEST_RESET;
    end else if (addr == REG_DEPTH_MODE) begin
      return wd & DEPTH_MASK;
    end else if (addr == REG_NOISE_FIFO || addr == REG_PKT_LEN) begin
      return 16'h0000;
    end
    return wd;
  endfunction : pds_merge

  function automatic logic [15:0] pds_rd_mask(input logic [4:0] addr, input logic [15:0] rd);
    if (addr == REG_TEST) begin
      return rd & TEST_SHADOW_MASK;
    end else if (addr == REG_DEPTH_MODE) begin
      return rd & DEPTH_MASK;
    end else if (addr == REG_NOISE_FIFO) begin
      return rd & NOISE_FIFO_RD_MASK;
    end
    return rd;
  endfunction : pds_rd_mask

  always_comb begin
    s_d = s_q;
    ev = 1'b0;
    s_d.ref_clk = ~s_q.ref_clk;
    s_d.mg_wr = 1'b0;
    s_d.mg_rd = 1'b0;
    s_d.resp_valid = 1'b0;
    s_d.tx_take = 1'b0;
    s_d.ref_sel = tx_ref_sel_in;
    s_d.txc_prev = link.tx_clk;
    case (s_q.state)
      HS_RESET: begin
        if (s_q.cnt == 16'(RESET_PULSE_CYC - 1)) begin
          s_d.cnt = '0;
          s_d.phy_rst = 1'b0;
          s_d.state = HS_WAIT;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end
      HS_WAIT: begin
        if (s_q.cnt == 16'(RESET_WAIT_CYC - 1)) begin
          s_d.state = HS_IDLE;
          s_d.ready = 1'b1;
          s_d.live = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end
      HS_IDLE: begin
        if (s_q.ready && (req_wr || req_rd)) begin
          s_d.ready = 1'b0;
          s_d.rq_wr = req_wr;
          s_d.mg_port = req_port;
          s_d.mg_addr = req_addr;
          // The enable write borrows the address pins, so the requested address is kept apart.
          s_d.rq_addr = req_addr;
          s_d.rq_wdata = req_wdata;
          if (req_addr >= REG_NOISE_FIFO && req_addr <= REG_PKT_LEN && !s_q.shadow_on[req_port]) begin
            s_d.state = HS_ENABLE;
          end else begin
            s_d.state = HS_ACCESS;
          end
        end
      end
      HS_ENABLE: begin
        // Opening the shadow bank costs one extra write before the requested access.
        s_d.mg_wr = 1'b1;
        s_d.mg_addr = REG_TEST;
        s_d.mg_wdata = TEST_SHADOW_ON;
        s_d.shadow_on[s_q.mg_port] = 1'b1;
        s_d.state = HS_ACCESS;
      end
      HS_ACCESS: begin
        s_d.mg_addr = s_q.rq_addr;
        s_d.mg_wdata = pds_merge(s_q.rq_addr, s_q.rq_wdata);
        s_d.mg_wr = s_q.rq_wr;
        s_d.mg_rd = !s_q.rq_wr;
        if (s_q.rq_wr) begin
          if (s_q.rq_addr == REG_TEST) begin
            s_d.shadow_on[s_q.mg_port] = s_q.rq_wdata[SHADOW_EN_BIT];
          end
          s_d.ready = 1'b1;
          s_d.state = HS_IDLE;
        end else begin
          s_d.state = HS_STROBE;
        end
      end
      HS_STROBE: begin
        s_d.state = HS_READ;
      end
      HS_READ: begin
        s_d.resp_data = pds_rd_mask(s_q.rq_addr, link.mg_rdata);
        s_d.resp_valid = 1'b1;
        s_d.ready = 1'b1;
        s_d.state = HS_IDLE;
      end
      default: begin
        s_d.state = HS_IDLE;
      end
    endcase

    for (int i = 0; i < NPORT; i++) begin
      // Pins change a half period before the device samples them on the transmit clock, a full period before on the reference clock.
      if (s_q.ref_sel) begin
        ev = s_q.ref_clk;
      end else begin
        ev = link.tx_clk[i] && !s_q.txc_prev[i];
      end
      if (ev) begin
        if (s_q.live && tx_valid && tx_port == PORT_W'(i)) begin
          s_d.tx_en[i] = 1'b1;
          s_d.txd[i] = tx_nibble;
          s_d.tx_take = 1'b1;
        end else begin
          s_d.tx_en[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= HOST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.phy_rst = s_q.phy_rst;
  assign link.ref_clock_in = s_q.ref_clk;
  assign link.tx_ref_sel = s_q.ref_sel;
  assign link.mg_port = s_q.mg_port;
  assign link.mg_addr = s_q.mg_addr;
  assign link.mg_wdata = s_q.mg_wdata;
  assign link.mg_wr = s_q.mg_wr;
  assign link.mg_rd = s_q.mg_rd;
  assign link.tx_en = s_q.tx_en;
  assign link.txd = s_q.txd;
  assign req_ready = s_q.ready;
  assign resp_valid = s_q.resp_valid;
  assign resp_data = s_q.resp_data;
  assign live = s_q.live;
  assign tx_take = s_q.tx_take;
endmodule : pds_host

// *** rtl/pds_pkg.sv ***
// Shared constants, register map and types for the diagnostic shadow register bank and its controller.
package pds_pkg;
  localparam int NPORT = 2;
  localparam int PORT_W = 1;
  localparam int CLK_NS = 20;

  // Register addresses on the management path.
  localparam logic [4:0] REG_NOISE_FIFO = 5'h1c;
  localparam logic [4:0] REG_DEPTH_MODE = 5'h1d;
  localparam logic [4:0] REG_PKT_LEN = 5'h1e;
  localparam logic [4:0] REG_TEST = 5'h1f;

  // Field layout and reset values.
  localparam int SHADOW_EN_BIT = 7;
  localparam logic [15:0] TEST_RESET = 16'h000b;
  localparam logic [15:0] TEST_KEEP_MASK = 16'h00bf;
  localparam logic [15:0] TEST_SHADOW_MASK = 16'h0080;
  localparam logic [15:0] TEST_SHADOW_ON = 16'h008b;
  localparam logic [15:0] DEPTH_RESET = 16'h0004;
  localparam logic [15:0] DEPTH_MASK = 16'h000f;
  localparam logic [15:0] NOISE_FIFO_RD_MASK = 16'hff0f;
  localparam logic [15:0] PKT_LEN_RESET = 16'h0000;
  localparam logic [3:0] RSVD_NIBBLE = 4'h0;
  localparam logic [3:0] DEPTH_CODE_MIN = 4'h1;
  localparam logic [3:0] DEPTH_CODE_MAX = 4'hd;
  localparam logic [6:0] DEPTH_BITS_BASE = 7'h0c;
  localparam logic [6:0] DEPTH_BITS_STEP = 7'h04;

  // Transmit side timing.
  localparam int TXC_PERIOD_NS = 40;
  localparam int TXC_HALF_CYC = TXC_PERIOD_NS / (2 * CLK_NS);
  localparam logic [3:0] TXC_HALF_LAST = 4'(TXC_HALF_CYC - 1);
  localparam int LINE_START_MIN_NS = 60;
  localparam int LINE_DELAY_CYC = (LINE_START_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int LINE_PIPE = LINE_DELAY_CYC - 1;

  // Hardware reset timing kept by the controller.
  localparam int RESET_PULSE_MIN_NS = 400;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_WAIT_US = 100;
  localparam int RESET_WAIT_CYC_DEF = (RESET_WAIT_US * 1000 + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    HS_RESET = 3'b000,
    HS_WAIT = 3'b001,
    HS_IDLE = 3'b010,
    HS_ENABLE = 3'b011,
    HS_ACCESS = 3'b100,
    HS_STROBE = 3'b110,
    HS_READ = 3'b101
  } pds_host_state_t;
endpackage : pds_pkg

// *** rtl/pds_link_if.sv ***
// Interface joining the transceiver shadow bank to its management and transmit controller.
`timescale 1ns/1ps
interface pds_link_if (
  input wire logic clock // Common clock.
);
  import pds_pkg::*;
  logic phy_rst;
  logic ref_clock_in;
  logic tx_ref_sel;
  logic [PORT_W-1:0] mg_port;
  logic [4:0] mg_addr;
  logic [15:0] mg_wdata;
  logic mg_wr;
  logic mg_rd;
  logic [15:0] mg_rdata;
  logic [NPORT-1:0] tx_clk;
  logic [NPORT-1:0] tx_en;
  logic [NPORT-1:0][3:0] txd;
  logic [NPORT-1:0] crs;

  modport device (
    input phy_rst, ref_clock_in, tx_ref_sel, mg_port, mg_addr, mg_wdata, mg_wr, mg_rd, tx_en, txd,
    output mg_rdata, tx_clk, crs
  );
  modport host (
    output phy_rst, ref_clock_in, tx_ref_sel, mg_port, mg_addr, mg_wdata, mg_wr, mg_rd, tx_en, txd,
    input mg_rdata, tx_clk, crs
  );
endinterface : pds_link_if

// *** rtl/pds_device.sv ***
// Transceiver end: per-port diagnostic shadow registers, transmit clock, carrier sense and line path.
//
// What this block and its controller do
// - Noise error value in status upper byte
// - Receive FIFO nibble fill in low bits
// - Depth selector, reset 4h, upper bits reserved
// - Depth codes 1 to 13 give 16-64 bits
// - Last packet byte count, read-only, resets zero
// - Byte count meaningful only with link up
// - Shadow addresses decode only while enable set
// - Software writes reserved defaults, ignores reads
// - Reset held 400 ns with reference running
// - Wait 100 us after reset release
// - 40 ns transmit clock, sampled rising
// - Transmit may follow reference clock instead
// - Carrier sense within 40 ns of enable
// - Carrier sense drops within 160 ns
// - Line delay 60-140 start, 60-100 steady
`timescale 1ns/1ps
module pds_device (
  input wire logic clock, // System clock, 50 MHz.
  input wire logic rst, // Synchronous reset, active high.
  pds_link_if.device link, // Management and transmit pins toward the controller.
  input wire logic [pds_pkg::NPORT-1:0] link_up, // Link established, per port.
  input wire logic [pds_pkg::NPORT-1:0][7:0] noise_mse, // Current noise mean-square error, per port.
  input wire logic [pds_pkg::NPORT-1:0][3:0] rx_fifo_fill, // Receive FIFO nibbles in use, per port.
  input wire logic [pds_pkg::NPORT-1:0] rx_byte, // One received byte, pulse, per port.
  input wire logic [pds_pkg::NPORT-1:0] rx_pkt_end, // End of received packet, pulse, per port.
  output logic [pds_pkg::NPORT-1:0][6:0] fifo_depth_bits, // Receive FIFO size in bits, per port.
  output logic [pds_pkg::NPORT-1:0] line_tx_active, // Line transmitter active, per port.
  output logic [pds_pkg::NPORT-1:0][3:0] line_tx_pair // Nibble going to the line, per port.
);
  import pds_pkg::*;

  typedef struct packed {
    logic [15:0] test;
    logic [15:0] depth;
    logic [15:0] pkt_len;
    logic [15:0] pkt_cnt;
    logic [6:0] depth_bits;
    logic [3:0] txc_cnt;
    logic txc;
    logic ref_prev;
    logic en_s;
    logic [3:0] d_s;
    logic crs;
    logic [LINE_PIPE-1:0][4:0] pipe;
  } pds_dev_port_t;

  typedef struct packed {
    logic [15:0] rdata;
    pds_dev_port_t [NPORT-1:0] p;
  } pds_dev_state_t;

  localparam pds_dev_port_t PORT_RST = '{
    test: TEST_RESET,
    depth: DEPTH_RESET,
    pkt_len: PKT_LEN_RESET,
    depth_bits: DEPTH_BITS_BASE + 7'(DEPTH_RESET[3:0]) * DEPTH_BITS_STEP,
    default: '0
  };
  localparam pds_dev_state_t DEV_RST = '{rdata: '0, p: {NPORT{PORT_RST}}};

  pds_dev_state_t s_q;
  pds_dev_state_t s_d;
  logic [NPORT-1:0] sample;
  logic [15:0] rd_word;
  logic [15:0] cnt_next;
  logic shadow_on;

  always_comb begin
    s_d = s_q;
    sample = '0;
    cnt_next = '0;
    for (int i = 0; i < NPORT; i++) begin
      // The transmit clock is a divided copy of the system clock; a sample is taken on its rising edge.
      if (s_q.p[i].txc_cnt == TXC_HALF_LAST) begin
        s_d.p[i].txc_cnt = '0;
        s_d.p[i].txc = ~s_q.p[i].txc;
      end else begin
        s_d.p[i].txc_cnt = s_q.p[i].txc_cnt + 4'h1;
      end
      if (link.tx_ref_sel) begin
        sample[i] = link.ref_clock_in && !s_q.p[i].ref_prev;
      end else begin
        sample[i] = !s_q.p[i].txc && (s_q.p[i].txc_cnt == TXC_HALF_LAST);
      end
      s_d.p[i].ref_prev = link.ref_clock_in;
      if (sample[i]) begin
        s_d.p[i].en_s = link.tx_en[i];
        s_d.p[i].d_s = link.txd[i];
        // Carrier follows the sampled enable in both directions, one cycle after the pin settles on the transmit clock, two on the reference clock.
        s_d.p[i].crs = link.tx_en[i];
      end
      // Fixed line pipeline: three cycles from pin change to line on the transmit clock, four on the reference clock, start and steady delay alike.
      s_d.p[i].pipe[0] = {s_q.p[i].en_s, s_q.p[i].d_s};
      for (int k = 1; k < LINE_PIPE; k++) begin
        s_d.p[i].pipe[k] = s_q.p[i].pipe[k-1];
      end
      // Without a link the count is meaningless, so it is held at zero rather than left drifting.
      cnt_next = s_q.p[i].pkt_cnt + {15'h0000, rx_byte[i]};
      if (!link_up[i]) begin
        s_d.p[i].pkt_cnt = '0;
      end else if (rx_pkt_end[i]) begin
        s_d.p[i].pkt_len = cnt_next;
        s_d.p[i].pkt_cnt = '0;
      end else begin
        s_d.p[i].pkt_cnt = cnt_next;
      end
      s_d.p[i].depth_bits = DEPTH_BITS_BASE + 7'(s_q.p[i].depth[3:0]) * DEPTH_BITS_STEP;
    end

    // Each port keeps its own bank; the port field selects which one is seen.
    shadow_on = s_q.p[link.mg_port].test[SHADOW_EN_BIT];
    rd_word = '0;
    if (link.mg_addr == REG_TEST) begin
      rd_word = s_q.p[link.mg_port].test;
    end else if (shadow_on && link.mg_addr == REG_NOISE_FIFO) begin
      rd_word = {noise_mse[link.mg_port], RSVD_NIBBLE, rx_fifo_fill[link.mg_port]};
    end else if (shadow_on && link.mg_addr == REG_DEPTH_MODE) begin
      rd_word = s_q.p[link.mg_port].depth & DEPTH_MASK;
    end else if (shadow_on && link.mg_addr == REG_PKT_LEN) begin
      rd_word = s_q.p[link.mg_port].pkt_len;
    end
    // Read data stands only in the cycle after the strobe.
    s_d.rdata = link.mg_rd ? rd_word : 16'h0000;

    if (link.mg_wr) begin
      if (link.mg_addr == REG_TEST) begin
        s_d.p[link.mg_port].test = link.mg_wdata & TEST_KEEP_MASK;
      end else if (shadow_on && link.mg_addr == REG_DEPTH_MODE) begin
        // Codes outside the table are dropped so the FIFO never takes an undefined size.
        if (link.mg_wdata[3:0] >= DEPTH_CODE_MIN && link.mg_wdata[3:0] <= DEPTH_CODE_MAX) begin
          s_d.p[link.mg_port].depth = link.mg_wdata & DEPTH_MASK;
        end
      end
    end
  end

  // The controller's hardware reset pin and the local reset both clear the bank.
  always_ff @(posedge clock) begin
    if (rst || link.phy_rst) begin
      s_q <= DEV_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.mg_rdata = s_q.rdata;

  for (genvar g = 0; g < NPORT; g++) begin : g_port
    assign link.tx_clk[g] = s_q.p[g].txc;
    assign link.crs[g] = s_q.p[g].crs;
    assign fifo_depth_bits[g] = s_q.p[g].depth_bits;
    assign line_tx_active[g] = s_q.p[g].pipe[LINE_PIPE-1][4];
    assign line_tx_pair[g] = s_q.p[g].pipe[LINE_PIPE-1][3:0];
  end
endmodule : pds_device

// *** verification/pds_link_asserts.sv ***
// Concurrent checks on the link between the shadow bank and its controller.
`timescale 1ns/1ps
module pds_link_asserts #(
  parameter int RESET_WAIT_CYC = 50 // Quiet time after reset release.
) (
  input wire logic clock, // Common clock.
  input wire logic rst, // Synchronous reset.
  input wire logic phy_rst, // Device reset.
  input wire logic [pds_pkg::PORT_W-1:0] mg_port, // Port select.
  input wire logic [4:0] mg_addr, // Address.
  input wire logic [15:0] mg_wdata, // Write data.
  input wire logic mg_wr, // Write strobe.
  input wire logic mg_rd, // Read strobe.
  input wire logic [15:0] mg_rdata, // Read data.
  input wire logic [pds_pkg::NPORT-1:0] tx_clk, // Transmit clocks.
  input wire logic [pds_pkg::NPORT-1:0] tx_en, // Transmit enables.
  input wire logic [pds_pkg::NPORT-1:0] crs // Carrier sense.
);
  import pds_pkg::*;
  logic [NPORT-1:0] open_q;
  logic [NPORT-1:0][3:0] code_q;
  logic [4:0] hold_q;
  logic [15:0] quiet_q;
  logic shadow;
  logic busy;
  assign shadow = open_q[mg_port];
  assign busy = mg_wr || mg_rd || (tx_en != '0);
  // Reset cycles count as one so the pulse counter never starts from an unknown.
  always_ff @(posedge clock) begin
    if (rst || phy_rst) begin
      open_q <= '0;
      code_q <= {NPORT{4'h4}};
    end else if (mg_wr && mg_addr == REG_TEST) begin
      open_q[mg_port] <= mg_wdata[SHADOW_EN_BIT];
    end else if (mg_wr && mg_addr == REG_DEPTH_MODE && shadow && mg_wdata[3:0] >= DEPTH_CODE_MIN
                 && mg_wdata[3:0] <= DEPTH_CODE_MAX) begin
      code_q[mg_port] <= mg_wdata[3:0];
    end
    hold_q <= rst ? 5'h01 : (!phy_rst ? 5'h00 : ((hold_q == 5'h1f) ? hold_q : hold_q + 5'h01));
    quiet_q <= (rst || phy_rst) ? 16'h0000 : ((quiet_q == 16'hffff) ? quiet_q : quiet_q + 16'h0001);
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_crs_assert: assert property ($rose(tx_en[0]) |-> ##[1:2] crs[0])
    else $error("carrier sense late after enable rise");
  a_crs_release: assert property ($fell(tx_en[0]) |-> ##[1:8] !crs[0])
    else $error("carrier sense held after enable fall");
  a_txclk_toggle: assert property (!phy_rst [*3] |-> (tx_clk ^ $past(tx_clk)) == {NPORT{1'b1}})
    else $error("transmit clock missed a toggle");
  a_rdata_quiet: assert property (!$past(mg_rd) |-> mg_rdata == 16'h0000)
    else $error("read data outside the answer cycle");
  a_unmapped_zero: assert property ((mg_rd && (mg_addr < REG_NOISE_FIFO || (!shadow && mg_addr != REG_TEST)))
    |=> mg_rdata == 16'h0000)
    else $error("unmapped or closed read not zero");
  a_depth_read: assert property ((mg_rd && mg_addr == REG_DEPTH_MODE && shadow)
    |=> mg_rdata == {12'h000, $past(code_q[mg_port])})
    else $error("depth selector read mismatch");
  a_status_rsvd: assert property ((mg_rd && mg_addr == REG_NOISE_FIFO && shadow) |=> mg_rdata[7:4] == 4'h0)
    else $error("status reserved bits not zero");
  a_reset_pulse_min: assert property ($fell(phy_rst) |-> hold_q >= 5'h14)
    else $error("device reset pulse too short");
  a_quiet_start: assert property (busy |-> !phy_rst && quiet_q >= 16'(RESET_WAIT_CYC))
    else $error("activity too soon after reset");
endmodule : pds_link_asserts

// *** verification/pds_link_tb.sv ***
// Self-checking bench driving both ends of the shadow bank link.
`timescale 1ns/1ps
module pds_link_tb;
  import pds_pkg::*;
  localparam int WAIT_CYC = 50;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [NPORT-1:0] link_up = '0;
  logic [NPORT-1:0][7:0] noise_mse = '0;
  logic [NPORT-1:0][3:0] rx_fifo_fill = '0;
  logic [NPORT-1:0] rx_byte = '0;
  logic [NPORT-1:0] rx_pkt_end = '0;
  logic [NPORT-1:0][6:0] fifo_depth_bits;
  logic [NPORT-1:0] line_tx_active;
  logic [NPORT-1:0][3:0] line_tx_pair;
  logic req_wr = 1'b0;
  logic req_rd = 1'b0;
  logic [PORT_W-1:0] req_port = '0;
  logic [4:0] req_addr = 5'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic req_ready, resp_valid, live, tx_take;
  logic [15:0] resp_data;
  logic tx_ref_sel_in = 1'b0;
  logic [PORT_W-1:0] tx_port = '0;
  logic tx_valid = 1'b0;
  logic [3:0] tx_nibble = 4'h0;
  int fails = 0;
  int total_checks = 0;
  always #10 clock = ~clock;
  pds_link_if link (.clock(clock));
  pds_device u_pds_device (.clock(clock), .rst(rst), .link(link.device), .link_up(link_up),
    .noise_mse(noise_mse), .rx_fifo_fill(rx_fifo_fill), .rx_byte(rx_byte), .rx_pkt_end(rx_pkt_end),
    .fifo_depth_bits(fifo_depth_bits), .line_tx_active(line_tx_active), .line_tx_pair(line_tx_pair));
  pds_host #(.RESET_WAIT_CYC(WAIT_CYC)) u_pds_host (.clock(clock), .rst(rst), .link(link.host),
    .req_wr(req_wr), .req_rd(req_rd), .req_port(req_port), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data), .live(live),
    .tx_ref_sel_in(tx_ref_sel_in), .tx_port(tx_port), .tx_valid(tx_valid), .tx_nibble(tx_nibble),
    .tx_take(tx_take));
  pds_link_asserts #(.RESET_WAIT_CYC(WAIT_CYC)) u_pds_link_asserts (.clock(clock), .rst(rst),
    .phy_rst(link.phy_rst), .mg_port(link.mg_port), .mg_addr(link.mg_addr), .mg_wdata(link.mg_wdata),
    .mg_wr(link.mg_wr), .mg_rd(link.mg_rd), .mg_rdata(link.mg_rdata), .tx_clk(link.tx_clk),
    .tx_en(link.tx_en), .crs(link.crs));

  task automatic end_of_test();
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  // Values read right after an edge are those of the cycle before it, so a strobe just sent is never seen as ready.
  task automatic wait_ready();
    for (int n = 0; req_ready !== 1'b1; n++) begin
      if (n > 200) begin
        fails++;
        end_of_test();
      end
      @(posedge clock);
    end
  endtask : wait_ready

  task automatic reg_wr(input logic [PORT_W-1:0] p, input logic [4:0] a, input logic [15:0] d);
    wait_ready();
    req_wr <= 1'b1;
    req_port <= p;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clock);
    req_wr <= 1'b0;
    @(posedge clock);
  endtask : reg_wr

  task automatic rd_chk(input logic [PORT_W-1:0] p, input logic [4:0] a, input logic [15:0] exp);
    int n;
    wait_ready();
    req_rd <= 1'b1;
    req_port <= p;
    req_addr <= a;
    @(posedge clock);
    req_rd <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (resp_valid !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      end_of_test();
    end
    chk16(resp_data, exp);
  endtask : rd_chk

  task automatic t_reset();
    rd_chk(1'b0, REG_DEPTH_MODE, DEPTH_RESET);
    rd_chk(1'b1, REG_PKT_LEN, PKT_LEN_RESET);
    chk16(16'(fifo_depth_bits[0]), 16'h001c);
    rd_chk(1'b0, 5'h10, 16'h0000);
  endtask : t_reset

  task automatic t_status();
    noise_mse <= {8'h3c, 8'ha5};
    rx_fifo_fill <= {4'h6, 4'h9};
    link_up <= 2'b11;
    @(posedge clock);
    rd_chk(1'b0, REG_NOISE_FIFO, 16'ha509);
    rd_chk(1'b1, REG_NOISE_FIFO, 16'h3c06);
    reg_wr(1'b0, REG_NOISE_FIFO, 16'h0000);
    rd_chk(1'b0, REG_NOISE_FIFO, 16'ha509);
  endtask : t_status

  task automatic t_depth();
    logic [3:0] cur;
    cur = 4'h4;
    for (int c = 0; c < 16; c++) begin
      reg_wr(1'b0, REG_DEPTH_MODE, {12'h000, 4'(c)});
      if (c >= 1 && c <= 13) begin
        cur = 4'(c);
      end
      rd_chk(1'b0, REG_DEPTH_MODE, {12'h000, cur});
      chk16(16'(fifo_depth_bits[0]), 16'h000c + 16'(cur) * 16'h0004);
    end
    chk16(16'(fifo_depth_bits[1]), 16'h001c);
  endtask : t_depth

  task automatic t_pkt();
    for (int i = 0; i < 5; i++) begin
      rx_byte <= 2'b10;
      rx_pkt_end <= (i == 4) ? 2'b10 : 2'b00;
      @(posedge clock);
    end
    rx_byte <= 2'b00;
    rx_pkt_end <= 2'b00;
    @(posedge clock);
    rd_chk(1'b1, REG_PKT_LEN, 16'h0005);
    rd_chk(1'b0, REG_PKT_LEN, 16'h0000);
    link_up <= 2'b01;
    rx_byte <= 2'b10;
    repeat (3) @(posedge clock);
    link_up <= 2'b11;
    rx_pkt_end <= 2'b10;
    @(posedge clock);
    rx_byte <= 2'b00;
    rx_pkt_end <= 2'b00;
    @(posedge clock);
    rd_chk(1'b1, REG_PKT_LEN, 16'h0001);
  endtask : t_pkt

  task automatic t_tx(input logic sel);
    logic [3:0] nib [3];
    logic [3:0] last;
    int idx, got, t_en, t_act;
    nib = '{4'ha, 4'h5, 4'hc};
    idx = 0;
    got = 0;
    t_en = -1;
    t_act = -1;
    last = 4'h0;
    tx_ref_sel_in <= sel;
    tx_nibble <= nib[0];
    tx_valid <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(posedge clock);
      if (link.tx_en[0] === 1'b1 && t_en < 0) begin
        t_en = n;
      end
      if (line_tx_active[0] === 1'b1 && t_act < 0) begin
        t_act = n;
      end
      if (line_tx_active[0] === 1'b1 && got < 3 && line_tx_pair[0] !== last) begin
        chk16(16'(line_tx_pair[0]), 16'(nib[got]));
        last = line_tx_pair[0];
        got++;
      end
      if (tx_take === 1'b1 && idx < 3) begin
        idx++;
        if (idx == 3) begin
          tx_valid <= 1'b0;
        end else begin
          tx_nibble <= nib[idx];
        end
      end
    end
    chk16(16'(got), 16'h0003);
    chk16(16'(t_en >= 0 && t_act - t_en >= 3 && t_act - t_en <= 7), 16'h0001);
    chk16(16'({line_tx_active[0], link.crs[0]}), 16'h0000);
  endtask : t_tx

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int n = 0; n < 300 && live !== 1'b1; n++) begin
      @(posedge clock);
    end
    if (live !== 1'b1) begin
      fails++;
      end_of_test();
    end
    t_reset();
    t_status();
    t_depth();
    t_pkt();
    t_tx(1'b0);
    t_tx(1'b1);
    end_of_test();
  end
endmodule : pds_link_tb
